/* src/airs_ctrl.sv */
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module airs_ctrl (
    input  wire logic                 CORE_CLK,
    input  wire logic                 RST,
    input  wire logic [2:0]           ADDR,
    input  wire logic [7:0]           WDATA,
    input  wire logic                 WR,
    input  wire logic                 RD,
    input  wire logic                 TRIGGER,
    input  wire logic                 VECTOR_ACK,
    output logic [7:0]                RDATA,
    output airs_pkg::airs_front_s     FRONT,
    output logic                      BUSY,
    output logic                      DONE_PULSE,
    output logic                      IRQ_REQ
);
    airs_pkg::airs_state_s r;
    airs_pkg::airs_state_s next_r;

    logic [6:0] div_half;
    logic       conv_tick;
    logic       wr_a;
    logic       wr_sel;
    logic       start_req;

    //////////////////////////////////////////////////////////////////////////
    // converter clock: one tick per divided period
    always_comb begin
        case (r.prescale)
            3'h0, 3'h1: div_half = airs_pkg::PS_ONE;
            default:    div_half = 7'(airs_pkg::PS_ONE << (r.prescale - 3'h1));
        endcase
        conv_tick = (r.ps_cnt == 7'(div_half * 7'h02 - 7'h01)) || (r.prescale == 3'h7 && r.ps_cnt == 7'h7F);
    end

    // map a latched select value to front-end controls
    function automatic airs_pkg::airs_front_s decode(input logic [7:0] sel);
        airs_pkg::airs_front_s f;
        logic [5:0] c;
        c            = sel[airs_pkg::CHAN_MSB:0];
        f.code       = c;
        f.ref_sel    = sel[airs_pkg::REF_MSB:airs_pkg::REF_LSB];
        f.int_ref_on = (f.ref_sel == airs_pkg::REF_INTERNAL);
        f.gain_20x   = 1'b0;
        f.temp_on    = 1'b0;
        if (c <= airs_pkg::CH_SE_LAST) begin
            f.src = airs_pkg::SRC_SINGLE;
        end else if (c <= airs_pkg::CH_DIFF_LAST) begin
            f.src      = airs_pkg::SRC_DIFF;
            f.gain_20x = c[0];
        end else if (c == airs_pkg::CH_GROUND) begin
            f.src = airs_pkg::SRC_GROUND;
        end else if (c == airs_pkg::CH_BANDGAP) begin
            f.src = airs_pkg::SRC_BANDGAP;
        end else if (c == airs_pkg::CH_TEMP) begin
            f.src     = airs_pkg::SRC_TEMP;
            f.temp_on = 1'b1;
        end else if (c <= airs_pkg::CH_CAL_LAST) begin
            f.src      = airs_pkg::SRC_OFFSET_CAL;
            f.gain_20x = c[0] | (c == 6'h23);
        end else begin
            f.src      = airs_pkg::SRC_DIFF_REV;
            f.gain_20x = c[0];
        end
        return f;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_r     = r;
        wr_a       = WR && (ADDR == airs_pkg::CTRL_STATUS_A_OFS);
        wr_sel     = WR && (ADDR == airs_pkg::IN_REF_SEL_OFS);
        start_req  = 1'b0;
        next_r.done_pulse = 1'b0;
        next_r.ps_cnt = conv_tick ? 7'h00 : 7'(r.ps_cnt + 7'h01);

        if (wr_sel) begin
            next_r.in_ref_sel = WDATA;
            if (WDATA[airs_pkg::REF_MSB:airs_pkg::REF_LSB]
                != r.in_ref_sel[airs_pkg::REF_MSB:airs_pkg::REF_LSB])
                next_r.long_next = 1'b1;
        end

        if (wr_a) begin
            next_r.enable    = WDATA[airs_pkg::EN_BIT];
            next_r.auto_trig = WDATA[airs_pkg::ATE_BIT];
            next_r.irq_en    = WDATA[airs_pkg::IRQE_BIT];
            next_r.prescale  = WDATA[airs_pkg::PS_MSB:0];
            // writing zero to start does nothing
            start_req = WDATA[airs_pkg::START_BIT] && WDATA[airs_pkg::EN_BIT];
            if (WDATA[airs_pkg::EN_BIT] && !r.enable)
                next_r.long_next = 1'b1;
        end
        if (r.auto_trig && TRIGGER && r.enable)
            start_req = 1'b1;

        // clearing requests win only where no completion lands this cycle
        if ((wr_a && WDATA[airs_pkg::DONE_BIT]) || VECTOR_ACK)
            next_r.done_flag = 1'b0;

        case (r.state)
            airs_pkg::ST_IDLE: begin
                if (start_req) begin
                    next_r.state      = airs_pkg::ST_CONV;
                    next_r.active_sel = wr_sel ? WDATA : r.in_ref_sel;
                    next_r.cyc_len    = (r.long_next || next_r.long_next)
                                        ? airs_pkg::CONV_LONG : airs_pkg::CONV_NORMAL;
                    next_r.long_next  = 1'b0;
                    next_r.cyc_cnt    = 5'h00;
                    next_r.ps_cnt     = 7'h00;
                end
            end
            airs_pkg::ST_CONV: begin
                if (wr_a && !WDATA[airs_pkg::EN_BIT]) begin
                    next_r.state = airs_pkg::ST_IDLE;
                end else if (conv_tick) begin
                    next_r.cyc_cnt = 5'(r.cyc_cnt + 5'h01);
                    if (r.cyc_cnt == 5'(r.cyc_len - 5'h01)) begin
                        // new selections written mid conversion are picked up here or on disable
                        next_r.state      = airs_pkg::ST_IDLE;
                        next_r.done_flag  = 1'b1;
                        next_r.done_pulse = 1'b1;
                        next_r.active_sel = next_r.in_ref_sel;
                    end
                end
            end
            default: next_r.state = airs_pkg::ST_IDLE;
        endcase

        if (next_r.state == airs_pkg::ST_IDLE)
            next_r.active_sel = next_r.in_ref_sel;
        next_r.busy  = (next_r.state == airs_pkg::ST_CONV);
        next_r.front = decode(next_r.active_sel);

        next_r.rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                airs_pkg::CTRL_STATUS_A_OFS:
                    next_r.rdata = {r.enable, r.busy, r.auto_trig, r.done_flag,
                                    r.irq_en, r.prescale};
                airs_pkg::IN_REF_SEL_OFS: next_r.rdata = r.in_ref_sel;
                default:                  next_r.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            r          <= '0;
            r.state    <= airs_pkg::ST_IDLE;
            r.front    <= decode(airs_pkg::REG_RESET);
        end else begin
            r <= next_r;
        end
    end

    logic irq_q;
    always_ff @(posedge CORE_CLK) begin
        if (RST)
            irq_q <= 1'b0;
        else
            irq_q <= next_r.done_flag && next_r.irq_en;
    end

    assign RDATA      = r.rdata;
    assign FRONT      = r.front;
    assign BUSY       = r.busy;
    assign DONE_PULSE = r.done_pulse;
    assign IRQ_REQ    = irq_q;
endmodule // airs_ctrl

/* src/airs_pkg.sv */
package airs_pkg;
    // register offsets on the plain register port
    localparam logic [2:0] CTRL_STATUS_A_OFS = 3'h6;
    localparam logic [2:0] IN_REF_SEL_OFS    = 3'h7;
    localparam logic [7:0] REG_RESET         = 8'h00;

    // control/status register A fields
    localparam int EN_BIT    = 7;
    localparam int START_BIT = 6;
    localparam int ATE_BIT   = 5;
    localparam int DONE_BIT  = 4;
    localparam int IRQE_BIT  = 3;
    localparam int PS_MSB    = 2;

    // input/reference select fields
    localparam int REF_MSB  = 7;
    localparam int REF_LSB  = 6;
    localparam int CHAN_MSB = 5;

    // reference codes
    localparam logic [1:0] REF_SUPPLY   = 2'h0;
    localparam logic [1:0] REF_EXT_PIN  = 2'h1;
    localparam logic [1:0] REF_INTERNAL = 2'h2;

    // channel codes
    localparam logic [5:0] CH_SE_LAST   = 6'h07;
    localparam logic [5:0] CH_DIFF_LAST = 6'h1F;
    localparam logic [5:0] CH_GROUND    = 6'h20;
    localparam logic [5:0] CH_BANDGAP   = 6'h21;
    localparam logic [5:0] CH_TEMP      = 6'h22;
    localparam logic [5:0] CH_CAL_LAST  = 6'h27;

    // conversion lengths in converter clock cycles
    localparam logic [4:0] CONV_NORMAL = 5'h0D;
    localparam logic [4:0] CONV_LONG   = 5'h19;

    localparam logic [6:0] PS_ONE = 7'h01;

    typedef enum logic [2:0] {
        SRC_SINGLE,
        SRC_DIFF,
        SRC_DIFF_REV,
        SRC_GROUND,
        SRC_BANDGAP,
        SRC_TEMP,
        SRC_OFFSET_CAL
    } airs_src_e;

    typedef enum logic {
        ST_IDLE,
        ST_CONV
    } airs_state_e;

    // settings seen by the analog front end
    typedef struct packed {
        airs_src_e  src;
        logic [5:0] code;
        logic [1:0] ref_sel;
        logic       gain_20x;
        logic       temp_on;
        logic       int_ref_on;
    } airs_front_s;

    typedef struct packed {
        airs_state_e state;
        logic        enable;
        logic        auto_trig;
        logic        done_flag;
        logic        irq_en;
        logic [2:0]  prescale;
        logic [7:0]  in_ref_sel;
        logic [7:0]  active_sel;
        logic        long_next;
        logic [6:0]  ps_cnt;
        logic [4:0]  cyc_cnt;
        logic [4:0]  cyc_len;
        logic [7:0]  rdata;
        airs_front_s front;
        logic        busy;
        logic        done_pulse;
    } airs_state_s;
endpackage

/* verif/airs_ctrl_sva.sv */
module airs_ctrl_sva (
    input wire logic                  CORE_CLK,
    input wire logic                  RST,
    input wire airs_pkg::airs_front_s FRONT,
    input wire logic                  BUSY,
    input wire logic                  DONE_PULSE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    sequence s_conv_end;
        $past(BUSY) && !BUSY;
    endsequence
    sequence s_quiet;
        ##1 !DONE_PULSE;
    endsequence
    a_temp_route: assert property (FRONT.code == 6'h22 |->
        FRONT.src == airs_pkg::SRC_TEMP && FRONT.temp_on) else $error("temp route");
    a_ref_decode: assert property (FRONT.int_ref_on == (FRONT.ref_sel == 2'h2))
        else $error("internal reference enable");
    a_front_hold: assert property (BUSY && $past(BUSY) |-> $stable(FRONT))
        else $error("settings moved mid conversion");
    a_single_end: assert property (FRONT.code <= 6'h07 |->
        FRONT.src == airs_pkg::SRC_SINGLE) else $error("single ended decode");
    a_gnd_bandgap: assert property (FRONT.code inside {6'h20, 6'h21} |->
        FRONT.src == (FRONT.code[0] ? airs_pkg::SRC_BANDGAP : airs_pkg::SRC_GROUND))
        else $error("ground or bandgap decode");
    a_diff_pairs: assert property (FRONT.code[4:3] != 2'h0 |-> FRONT.src ==
        (FRONT.code[5] ? airs_pkg::SRC_DIFF_REV : airs_pkg::SRC_DIFF)) else $error("pair decode");
    a_diff_gain: assert property (FRONT.code[4:3] != 2'h0 |->
        FRONT.gain_20x == FRONT.code[0]) else $error("gain bit");
    a_cal_short: assert property (FRONT.code inside {[6'h23:6'h27]} |->
        FRONT.src == airs_pkg::SRC_OFFSET_CAL) else $error("calibration decode");
    a_done_once: assert property (DONE_PULSE |-> s_conv_end and s_quiet)
        else $error("done pulse not at conversion end");
endmodule // airs_ctrl_sva
bind airs_ctrl airs_ctrl_sva u_sva (.CORE_CLK, .RST, .FRONT, .BUSY, .DONE_PULSE);

/* verif/airs_ctrl_test.sv */
module airs_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  CORE_CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0;
    logic                  TRIGGER = 1'b0, VECTOR_ACK = 1'b0, BUSY, DONE_PULSE, IRQ_REQ;
    logic [2:0]            ADDR = 3'h0;
    logic [7:0]            WDATA = 8'h00, RDATA;
    airs_pkg::airs_front_s FRONT;
    int                    err_count = 0, n_compared = 0;
    logic [5:0] codes [10] = '{6'h00, 6'h07, 6'h08, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h23,
                               6'h28, 6'h3F};
    logic [2:0] srcs [10] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h2, 3'h2};
    // gain expected per entry of codes: set only for the 20x pair codes 1F and 3F and calibration code 23
    logic [9:0] gains = 10'h288;
    always #5 CORE_CLK = ~CORE_CLK;
    airs_ctrl u_dut (.CORE_CLK, .RST, .ADDR, .WDATA, .WR, .RD, .TRIGGER, .VECTOR_ACK,
                     .RDATA, .FRONT, .BUSY, .DONE_PULSE, .IRQ_REQ);
    //////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("mismatches %0d, compares %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        n_compared++;
        if (got !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CORE_CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge CORE_CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CORE_CLK);
        RD <= 1'b0;
        #1 chk(RDATA, e);
    endtask
    task automatic pulse(input bit trig);
        @(posedge CORE_CLK);
        if (trig) TRIGGER <= 1'b1;
        else VECTOR_ACK <= 1'b1;
        @(posedge CORE_CLK);
        TRIGGER    <= 1'b0;
        VECTOR_ACK <= 1'b0;
    endtask
    // counts system clocks with busy high; e of zero skips the count check
    task automatic wait_done(input int e);
        int n;
        n = 0;
        #1;
        while (BUSY === 1'b1 && n < 3000) begin
            @(posedge CORE_CLK);
            #1 n++;
        end
        if (n >= 3000) begin
            err_count++;
            $display("Error at %0t: conversion never finished", $time);
            report_and_stop();
        end else begin
            chk(8'(DONE_PULSE), 8'h01);
            if (e > 0) chk(8'(n), 8'(e));
        end
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge CORE_CLK);
        RST <= 1'b0;
        rd(3'h6, 8'h00);
        rd(3'h7, 8'h00);
        wr(3'h0, 8'hFF);
        rd(3'h0, 8'h00);
        // reference code steps through all four values, the reserved one included
        for (int i = 0; i < 10; i++) begin
            wr(3'h7, {2'(i), codes[i]});
            rd(3'h7, {2'(i), codes[i]});
            chk(8'(FRONT.src), 8'(srcs[i]));
            chk(8'(FRONT.code), 8'(codes[i]));
            chk(8'(FRONT.int_ref_on), 8'(i % 4 == 2));
            chk(8'(FRONT.gain_20x), 8'(gains[i]));
            chk(8'(FRONT.temp_on), 8'(codes[i] == 6'h22));
        end
        wr(3'h7, 8'h00);
        wr(3'h6, 8'hC0);
        wait_done(50);
        rd(3'h6, 8'h90);
        wr(3'h6, 8'h91);
        rd(3'h6, 8'h81);
        wr(3'h6, 8'hC1);
        wait_done(26);
        pulse(1'b0);
        rd(3'h6, 8'h81);
        wr(3'h6, 8'hC2);
        wr(3'h7, 8'hA2);
        #1 chk(8'(FRONT.ref_sel), 8'h00);
        chk(8'(FRONT.temp_on), 8'h00);
        rd(3'h6, 8'hC2);
        wait_done(0);
        @(posedge CORE_CLK);
        #1 chk(8'(FRONT.ref_sel), 8'h02);
        chk(8'(FRONT.temp_on), 8'h01);
        // converter stays enabled after the reference switch; the next conversion is checked for the long 100-clock length
        wr(3'h6, 8'hD2);
        wait_done(100);
        wr(3'h6, 8'hD2);
        wr(3'h6, 8'h00);
        rd(3'h6, 8'h00);
        wr(3'h6, 8'hC8);
        wait_done(50);
        @(posedge CORE_CLK);
        #1 chk(8'(IRQ_REQ), 8'h01);
        pulse(1'b0);
        @(posedge CORE_CLK);
        #1 chk(8'(IRQ_REQ), 8'h00);
        wr(3'h6, 8'hA8);
        pulse(1'b1);
        wait_done(26);
        report_and_stop();
    end
endmodule // airs_ctrl_test
